// [core/acsr_device.sv]
`timescale 1ns/1ps
// How it works
// RQ1 - Chosen channels convert in ascending order
// RQ2 - Source pin low: pins; high: register
// RQ3 - Channel included if chosen at start rise
// RQ4 - Latch choice at start until sequence ends
// RQ5 - Register bit n is channel n+1
// RQ6 - Low data lines written on write rise
// RQ7 - Register keeps value until next write
// RQ8 - Software mode: pins one,two are clocking
// RQ9 - Host ties pins three,four in software mode
// RQ10 - Start rise holds all four, begins sequence
// RQ11 - Each result ready every conversion time
// RQ12 - Done pulse low at each conversion end
// RQ13 - Busy high until all chosen converted
// RQ14 - Data driven only while select, read low; the drive is registered here, so it starts and stops one cycle late
// RQ15 - Host may read on done rising edge
// RQ16 - Host reads in done low, quiet before start
// RQ17 - Pointer reset at first done, flag high
// RQ18 - Read advances pointer only if next exists
// RQ19 - Early reads repeat current result
// RQ20 - Flag level after power-up undefined
// RQ21 - Reading last result wraps pointer to first
// RQ22 - Results in twos complement coding
// RQ23 - Four result registers filled in order
// RQ24 - Start ignored while sequence runs
module acsr_device (
  input  wire logic                     ref_clk_in,
  input  wire logic                     resetn_in,
  input  wire logic                     ce_in,
  input  wire logic [acsr_pkg::NUM_CHAN-1:0][acsr_pkg::DATA_W-1:0]
                                        chan_code_in,
  output logic [acsr_pkg::NUM_CHAN-1:0] latched_choice_out,
  output logic                          clk_src_ext_out,
  acsr_if.dev                           link
);

  // ========================================================================
  // Declarations
  typedef enum logic {ACSR_IDLE, ACSR_CONV} acsr_state_t;

  acsr_state_t                          state_q;
  logic                                 start_prev_q;
  logic                                 rd_prev_q;
  logic                                 wr_prev_q;
  logic [acsr_pkg::NUM_CHAN-1:0]        chan_reg_q;
  logic [acsr_pkg::NUM_CHAN-1:0]        wr_shadow_q;
  logic [acsr_pkg::NUM_CHAN-1:0]        choice_q;
  logic [acsr_pkg::NUM_CHAN-1:0]        todo_q;
  logic [acsr_pkg::NUM_CHAN-1:0][acsr_pkg::DATA_W-1:0] held_q;
  logic [acsr_pkg::NUM_CHAN-1:0][acsr_pkg::DATA_W-1:0] res_q;
  logic [acsr_pkg::CONV_W-1:0]          cnt_q;
  logic [acsr_pkg::CNT_W-1:0]           nsel_q;
  logic [acsr_pkg::CNT_W-1:0]           nres_q;
  logic [acsr_pkg::CONV_W-1:0]          eoc_cnt_q;
  logic                                 eoc_n_q;
  logic                                 busy_q;
  logic [acsr_pkg::PTR_W-1:0]           ptr_q;
  logic [acsr_pkg::PTR_W-1:0]           ptr_d;
  logic                                 pend_q;
  logic                                 pend_d;
  logic                                 flag_q;
  logic [acsr_pkg::DATA_W-1:0]          data_q;
  logic                                 oe_q;
  logic                                 clk_src_q;
  logic [acsr_pkg::NUM_CHAN-1:0]        choice_src;
  logic                                 start_rise;
  logic                                 rd_rise;
  logic                                 wr_rise;
  logic                                 wr_active;
  logic                                 conv_end;
  logic [acsr_pkg::PTR_W-1:0]           cur_idx;
  logic [acsr_pkg::NUM_CHAN-1:0]        todo_left;

  // Index of the lowest set bit: this is what fixes ascending order
  function automatic logic [acsr_pkg::PTR_W-1:0] lowest_idx
    (input logic [acsr_pkg::NUM_CHAN-1:0] m);
    logic [acsr_pkg::PTR_W-1:0] r;
    r = '0;
    for (int i = acsr_pkg::NUM_CHAN - 1; i >= 0; i--)
    begin
      if (m[i])
        r = acsr_pkg::PTR_W'(i);
    end
    return r;
  endfunction : lowest_idx

  // Number of chosen channels
  function automatic logic [acsr_pkg::CNT_W-1:0] count_ones
    (input logic [acsr_pkg::NUM_CHAN-1:0] m);
    logic [acsr_pkg::CNT_W-1:0] r;
    r = '0;
    for (int i = 0; i < acsr_pkg::NUM_CHAN; i++)
    begin
      r = r + acsr_pkg::CNT_W'(m[i]);
    end
    return r;
  endfunction : count_ones

  // ========================================================================
  // Strobe edges; link inputs are synchronous so no resync stage is needed
  assign start_rise = link.sample_start_n & ~start_prev_q;
  assign rd_rise    = link.rd_n & ~rd_prev_q & ~link.cs_n;
  assign wr_rise    = link.wr_n & ~wr_prev_q & ~link.cs_n;
  assign wr_active  = ~link.cs_n & ~link.wr_n & link.rd_n;           // RQ6

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      start_prev_q <= 1'h1;
      rd_prev_q    <= 1'h1;
      wr_prev_q    <= 1'h1;
    end
    else if (ce_in)
    begin
      start_prev_q <= link.sample_start_n;
      rd_prev_q    <= link.rd_n;
      wr_prev_q    <= link.wr_n;
    end
  end

  // ========================================================================
  // Channel register: the shadow tracks the bus while the write is low,
  // because on the rising cycle the host may already have let go of it
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_shadow_q <= acsr_pkg::CHAN_REG_RST;
      chan_reg_q  <= acsr_pkg::CHAN_REG_RST;
    end
    else if (ce_in)
    begin
      if (wr_active)
        wr_shadow_q <= link.data_line[acsr_pkg::NUM_CHAN-1:0];       // RQ5
      if (wr_rise)
        chan_reg_q <= wr_shadow_q;                              // RQ6 RQ7
    end
  end

  // Source multiplexer; in software mode pins one and two are clocking
  // pins and never count as channel picks
  assign choice_src = link.sel_source ? chan_reg_q :                 // RQ2
                      {link.pick_pin_four, link.pick_pin_three,
                       link.pick_pin_two, link.pick_pin_one};        // RQ8

  // Clock choice is only watched; the block always runs on its own clock
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      clk_src_q <= acsr_pkg::CLK_SRC_INT;
    else if (ce_in && link.sel_source)
      clk_src_q <= link.pick_pin_two;                                // RQ8
  end

  // ========================================================================
  // Conversion sequencer
  assign conv_end  = (state_q == ACSR_CONV) && (cnt_q == '0);
  assign cur_idx   = lowest_idx(todo_q);                             // RQ1
  assign todo_left = todo_q & ~(4'h1 << cur_idx);

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q  <= ACSR_IDLE;
      choice_q <= '0;
      todo_q   <= '0;
      held_q   <= '0;
      res_q    <= '0;
      cnt_q    <= '0;
      nsel_q   <= '0;
      nres_q   <= '0;
      busy_q   <= 1'h0;
    end
    else if (ce_in)
    begin
      case (state_q)
        ACSR_IDLE:
        begin
          // An empty choice starts nothing
          if (start_rise && (choice_src != '0))                      // RQ3
          begin
            choice_q <= choice_src;                                  // RQ4
            todo_q   <= choice_src;
            held_q   <= chan_code_in;                               // RQ10
            cnt_q    <= acsr_pkg::CONV_W'(acsr_pkg::CONV_CYCLES - 1);
            nsel_q   <= count_ones(choice_src);
            nres_q   <= '0;
            busy_q   <= 1'h1;                                       // RQ13
            state_q  <= ACSR_CONV;
          end
        end
        ACSR_CONV:
        begin
          // Start edges are ignored here                           // RQ24
          if (conv_end)
          begin
            res_q[nres_q[acsr_pkg::PTR_W-1:0]] <= held_q[cur_idx];  // RQ23
            todo_q <= todo_left;
            nres_q <= nres_q + 3'h1;
            cnt_q  <= acsr_pkg::CONV_W'(acsr_pkg::CONV_CYCLES - 1); // RQ11
            if (todo_left == '0)
            begin
              busy_q  <= 1'h0;                                      // RQ13
              state_q <= ACSR_IDLE;
            end
          end
          else
            cnt_q <= cnt_q - 10'h001;
        end
        default:
          state_q <= ACSR_IDLE;
      endcase
    end
  end

  // Done pulse; it may overlap the start of the next conversion
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      eoc_n_q   <= 1'h1;
      eoc_cnt_q <= '0;
    end
    else if (ce_in)
    begin
      if (conv_end)
      begin
        eoc_n_q   <= 1'h0;                                          // RQ12
        eoc_cnt_q <= acsr_pkg::CONV_W'(acsr_pkg::EOC_LOW_CYCLES - 1);
      end
      else if (!eoc_n_q)
      begin
        if (eoc_cnt_q == '0)
          eoc_n_q <= 1'h1;
        else
          eoc_cnt_q <= eoc_cnt_q - 10'h001;
      end
    end
  end

  // ========================================================================
  // Output pointer: a read asks for the next result; if it does not exist
  // yet the request waits for the end of that conversion
  always_comb
  begin
    ptr_d  = ptr_q;
    pend_d = pend_q;
    if (rd_rise)
    begin
      if ((nres_q == nsel_q) &&
          (({1'b0, ptr_q} + 3'h1) == nsel_q))
        ptr_d = '0;                                                 // RQ21
      else if (({1'b0, ptr_q} + 3'h1) < nres_q)
        ptr_d = ptr_q + 2'h1;                                       // RQ18
      else
        pend_d = 1'h1;                                              // RQ19
    end
    if (conv_end)
    begin
      if (nres_q == '0)
      begin
        ptr_d  = '0;                                                // RQ17
        pend_d = 1'h0;
      end
      else if (pend_d)
      begin
        ptr_d  = ptr_q + 2'h1;                                      // RQ18
        pend_d = 1'h0;
      end
    end
  end

  // Flag starts high; any power-up level is allowed so this is safe
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ptr_q  <= '0;
      pend_q <= 1'h0;
      flag_q <= 1'h1;                                               // RQ20
    end
    else if (ce_in)
    begin
      ptr_q  <= ptr_d;
      pend_q <= pend_d;
      flag_q <= (ptr_d == '0);                                      // RQ17
    end
  end

  // ========================================================================
  // Read data path; the new result is visible in the cycle after its end,
  // together with the falling done edge
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      data_q <= '0;
      oe_q   <= 1'h0;
    end
    else if (ce_in)
    begin
      if (conv_end && (nres_q[acsr_pkg::PTR_W-1:0] == ptr_d))
        data_q <= held_q[cur_idx];                                  // RQ22
      else
        data_q <= res_q[ptr_d];
      oe_q <= ~link.cs_n & ~link.rd_n;                              // RQ14
    end
  end

  assign link.eoc_n             = eoc_n_q;
  assign link.busy              = busy_q;
  assign link.first_result_flag = flag_q;
  assign link.dev_data_out      = data_q;
  assign link.dev_data_oe       = oe_q;
  assign latched_choice_out     = choice_q;
  assign clk_src_ext_out        = clk_src_q;

endmodule : acsr_device

// [core/acsr_host.sv]
`timescale 1ns/1ps
// ==========================================================================
// Host end: strobes writes, starts and reads on the parallel link
module acsr_host (
  input  wire logic                         ref_clk_in,
  input  wire logic                         resetn_in,
  input  wire logic                         ce_in,
  input  wire logic                         sw_select_in,
  input  wire logic [acsr_pkg::NUM_CHAN-1:0] pick_in,
  input  wire logic                         wr_req_in,
  input  wire logic [acsr_pkg::NUM_CHAN-1:0] wr_chan_in,
  input  wire logic                         start_req_in,
  input  wire logic                         rd_req_in,
  output logic                              ready_out,
  output logic [acsr_pkg::DATA_W-1:0]       rd_data_out,
  output logic                              rd_valid_out,
  output logic                              rd_first_out,
  acsr_if.host                              link
);

  typedef enum logic [2:0] {H_IDLE, H_WR, H_RD, H_ST, H_END, H_QUIET}
    acsr_hstate_t;

  acsr_hstate_t                 st_q;
  logic [acsr_pkg::HCNT_W-1:0]  cnt_q;
  logic                         start_n_q;
  logic                         cs_n_q;
  logic                         rd_n_q;
  logic                         wr_n_q;
  logic [acsr_pkg::DATA_W-1:0]  dout_q;
  logic                         oe_q;
  logic                         sel_q;
  logic [acsr_pkg::NUM_CHAN-1:0] pick_q;
  logic [acsr_pkg::DATA_W-1:0]  rdata_q;
  logic                         rvalid_q;
  logic                         rfirst_q;

  // ========================================================================
  // Mode pins: in software mode pins one,two pick internal clocking and
  // pins three,four are tied low rather than left floating
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sel_q  <= 1'h0;
      pick_q <= '0;
    end
    else if (ce_in)
    begin
      sel_q  <= sw_select_in;
      pick_q <= sw_select_in ? {2'h0, acsr_pkg::CLK_SRC_INT, 1'h0}   // RQ9
                             : pick_in;
    end
  end

  // ========================================================================
  // Strobe sequencer; every access ends with a quiet gap, so a start
  // always follows the last read by at least the quiet time
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_q      <= H_IDLE;
      cnt_q     <= '0;
      start_n_q <= 1'h1;
      cs_n_q    <= 1'h1;
      rd_n_q    <= 1'h1;
      wr_n_q    <= 1'h1;
      dout_q    <= '0;
      oe_q      <= 1'h0;
      rdata_q   <= '0;
      rvalid_q  <= 1'h0;
      rfirst_q  <= 1'h0;
    end
    else if (ce_in)
    begin
      rvalid_q <= 1'h0;
      case (st_q)
        H_IDLE:
        begin
          cnt_q <= acsr_pkg::HCNT_W'(acsr_pkg::STROBE_CYCLES - 1);
          if (wr_req_in)
          begin
            cs_n_q <= 1'h0;
            wr_n_q <= 1'h0;
            oe_q   <= 1'h1;
            dout_q <= {10'h000, wr_chan_in};                         // RQ5
            st_q   <= H_WR;
          end
          else if (rd_req_in)
          begin
            cs_n_q <= 1'h0;
            rd_n_q <= 1'h0;
            st_q   <= H_RD;
          end
          else if (start_req_in)
          begin
            start_n_q <= 1'h0;
            st_q      <= H_ST;
          end
        end
        H_WR, H_RD, H_ST:
        begin
          if (cnt_q == '0)
          begin
            // Rising strobe edges; bus data is still held this cycle
            wr_n_q    <= 1'h1;                                       // RQ6
            rd_n_q    <= 1'h1;
            start_n_q <= 1'h1;
            if (st_q == H_RD)
            begin
              rdata_q  <= link.data_line;
              rfirst_q <= link.first_result_flag;
              rvalid_q <= 1'h1;
            end
            st_q <= H_END;
          end
          else
            cnt_q <= cnt_q - 6'h01;
        end
        H_END:
        begin
          cs_n_q <= 1'h1;
          oe_q   <= 1'h0;
          cnt_q  <= acsr_pkg::HCNT_W'(acsr_pkg::QUIET_CYCLES - 1);
          st_q   <= H_QUIET;
        end
        H_QUIET:
        begin
          if (cnt_q == '0)
            st_q <= H_IDLE;                                         // RQ16
          else
            cnt_q <= cnt_q - 6'h01;
        end
        default:
          st_q <= H_IDLE;
      endcase
    end
  end

  assign ready_out           = (st_q == H_IDLE);
  assign rd_data_out         = rdata_q;
  assign rd_valid_out        = rvalid_q;
  assign rd_first_out        = rfirst_q;
  assign link.sample_start_n = start_n_q;
  assign link.cs_n           = cs_n_q;
  assign link.rd_n           = rd_n_q;
  assign link.wr_n           = wr_n_q;
  assign link.sel_source     = sel_q;
  assign link.pick_pin_one   = pick_q[0];
  assign link.pick_pin_two   = pick_q[1];
  assign link.pick_pin_three = pick_q[2];
  assign link.pick_pin_four  = pick_q[3];
  assign link.host_data_out  = dout_q;
  assign link.host_data_oe   = oe_q;

endmodule : acsr_host

// [core/acsr_if.sv]
`timescale 1ns/1ps
// ==========================================================================
// Parallel link between the converter end and the host end
interface acsr_if;
  logic                         sample_start_n;
  logic                         cs_n;
  logic                         rd_n;
  logic                         wr_n;
  logic                         sel_source;
  logic                         pick_pin_one;
  logic                         pick_pin_two;
  logic                         pick_pin_three;
  logic                         pick_pin_four;
  logic                         eoc_n;
  logic                         busy;
  logic                         first_result_flag;
  logic [acsr_pkg::DATA_W-1:0]  dev_data_out;
  logic                         dev_data_oe;
  logic [acsr_pkg::DATA_W-1:0]  host_data_out;
  logic                         host_data_oe;
  logic [acsr_pkg::DATA_W-1:0]  data_line;

  // Resolved bus level; an undriven bus is modelled as pulled high
  assign data_line = dev_data_oe  ? dev_data_out  :
                     host_data_oe ? host_data_out : acsr_pkg::BUS_IDLE_LVL;

  modport dev (
    input  sample_start_n, cs_n, rd_n, wr_n, sel_source,
    input  pick_pin_one, pick_pin_two, pick_pin_three, pick_pin_four,
    input  data_line,
    output eoc_n, busy, first_result_flag, dev_data_out, dev_data_oe
  );

  modport host (
    output sample_start_n, cs_n, rd_n, wr_n, sel_source,
    output pick_pin_one, pick_pin_two, pick_pin_three, pick_pin_four,
    output host_data_out, host_data_oe,
    input  eoc_n, busy, first_result_flag, data_line
  );
endinterface : acsr_if

// [core/acsr_pkg.sv]
// ==========================================================================
// Shared constants for the sequencer/readout block and its host
package acsr_pkg;

  // ========================================================================
  // Widths
  localparam int NUM_CHAN   = 4;
  localparam int DATA_W     = 14;
  localparam int PTR_W      = 2;
  localparam int CNT_W      = 3;

  // ========================================================================
  // Timing: figures in ns, cycle counts derived from the 250 MHz clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int CONV_TIME_NS  = 2400;
  localparam int CONV_CYCLES   =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_W        = 10;
  localparam int EOC_LOW_NS    = 100;
  localparam int EOC_LOW_CYCLES =
    (EOC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_NS      = 150;
  localparam int QUIET_CYCLES  =
    (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES = 4;
  localparam int HCNT_W        = 6;

  // ========================================================================
  // Values after reset
  localparam logic [NUM_CHAN-1:0] CHAN_REG_RST  = 4'hF;
  localparam logic [DATA_W-1:0]   BUS_IDLE_LVL  = 14'h3FFF;
  localparam logic                CLK_SRC_INT   = 1'h0;

endpackage : acsr_pkg

// [verification/acsr_chk.sv]
`timescale 1ns/1ps
// ======================================================================
// Wire-level properties of the converter end
module acsr_chk (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic sample_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic eoc_n,
  input wire logic busy,
  input wire logic first_result_flag,
  input wire logic dev_data_oe
);
  logic [9:0] gap_q;    // Cycles since busy rise or done fall
  logic [2:0] idx_q;    // Done falls in the current sequence
  logic       busy_p_q;
  logic       eoc_p_q;

  // Edge history in flops keeps the counters free of sampled functions
  always_ff @(posedge ref_clk_in or negedge resetn_in)
    if (!resetn_in)
      {busy_p_q, eoc_p_q} <= 2'h1;
    else
      {busy_p_q, eoc_p_q} <= {busy, eoc_n};

  // Busy rise restarts at 1 like a done fall: each interval is equal
  always_ff @(posedge ref_clk_in or negedge resetn_in)
    if (!resetn_in)
    begin
      gap_q <= 10'h000;
      idx_q <= 3'h0;
    end
    else if (busy && !busy_p_q)
    begin
      gap_q <= 10'h001;
      idx_q <= 3'h0;
    end
    else if (!eoc_n && eoc_p_q)
    begin
      gap_q <= 10'h001;
      idx_q <= idx_q + 3'h1;
    end
    else if (gap_q != 10'h3FF)
      gap_q <= gap_q + 10'h001;

  // ======================================================================
  // Properties
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  // Low phase of one done pulse, then its release
  sequence s_eoc_low;
    !eoc_n throughout (##24 1'b1);
  endsequence
  sequence s_eoc_pulse;
    s_eoc_low ##1 eoc_n;
  endsequence

  property p_oe_follows_read;
    1'b1 |=> dev_data_oe == $past(!cs_n && !rd_n);
  endproperty
  a_oe_follows_read: assert property (p_oe_follows_read)
    else $error("data drive does not follow select and read");
  property p_busy_cause;
    $rose(busy) |-> $past(sample_start_n) && !$past(sample_start_n, 2);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose without a start edge");
  property p_conv_gap;
    $fell(eoc_n) |-> gap_q == 10'(acsr_pkg::CONV_CYCLES);
  endproperty
  a_conv_gap: assert property (p_conv_gap)
    else $error("conversion interval wrong");
  property p_eoc_width;
    $fell(eoc_n) |-> s_eoc_pulse;
  endproperty
  a_eoc_width: assert property (p_eoc_width)
    else $error("done pulse width wrong");
  property p_eoc_in_seq;
    $fell(eoc_n) |-> $past(busy);
  endproperty
  a_eoc_in_seq: assert property (p_eoc_in_seq)
    else $error("done pulse outside a sequence");
  property p_busy_end;
    $fell(busy) |-> $fell(eoc_n);
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy fell away from the last done edge");
  property p_flag_first;
    $fell(eoc_n) && idx_q == 3'h0 |-> first_result_flag;
  endproperty
  a_flag_first: assert property (p_flag_first)
    else $error("first flag low at first result");
  property p_read_advance;
    !busy && $rose(rd_n) && !cs_n && first_result_flag && idx_q > 3'h1
      |-> ##[1:2] !first_result_flag;
  endproperty
  a_read_advance: assert property (p_read_advance)
    else $error("read did not advance pointer");
  property p_wrap_single;
    !busy && $rose(rd_n) && !cs_n && idx_q == 3'h1
      |=> first_result_flag [*2];
  endproperty
  a_wrap_single: assert property (p_wrap_single)
    else $error("pointer left the first result");
endmodule : acsr_chk

// [verification/test_adc_sequence_and_readout.sv]
`timescale 1ns/1ps
// ======================================================================
// Both link ends joined; reads compared with a queue model
module test_adc_sequence_and_readout;
  logic             ref_clk_in   = 1'b0;
  logic             resetn_in    = 1'b0;
  logic             sw_select_in = 1'b0;
  logic             wr_req_in    = 1'b0;
  logic             start_req_in = 1'b0;
  logic             rd_req_in    = 1'b0;
  logic [3:0]       pick_in      = 4'h0;
  logic [3:0]       wr_chan_in   = 4'h0;
  logic [3:0][13:0] codes        = '0;
  logic [31:0]      rng          = 32'h4790A914;
  logic             eoc_p        = 1'b1;
  logic [3:0]       latched;
  logic             ready;
  logic             rd_first;
  logic             clk_src;
  logic [13:0]      rd_data;
  logic [13:0]      exp_q[$];
  int               n_mismatch   = 0;
  int               num_checks   = 0;
  int               eoc_falls    = 0;

  acsr_if link_if ();
  acsr_device acsr_device_inst (.ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in), .ce_in(1'b1), .chan_code_in(codes),
    .latched_choice_out(latched), .clk_src_ext_out(clk_src),
    .link(link_if));
  acsr_host acsr_host_inst (.ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in), .ce_in(1'b1), .sw_select_in(sw_select_in),
    .pick_in(pick_in), .wr_req_in(wr_req_in), .wr_chan_in(wr_chan_in),
    .start_req_in(start_req_in), .rd_req_in(rd_req_in),
    .ready_out(ready), .rd_data_out(rd_data), .rd_valid_out(),
    .rd_first_out(rd_first), .link(link_if));
  acsr_chk acsr_chk_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .sample_start_n(link_if.sample_start_n), .cs_n(link_if.cs_n),
    .rd_n(link_if.rd_n), .eoc_n(link_if.eoc_n), .busy(link_if.busy),
    .first_result_flag(link_if.first_result_flag),
    .dev_data_oe(link_if.dev_data_oe));

  // 4 ns clock
  always #2 ref_clk_in = ~ref_clk_in;

  // Done falls counted as the model's tally of finished conversions
  always @(posedge ref_clk_in)
  begin
    if (eoc_p && link_if.eoc_n === 1'b0)
      eoc_falls++;
    eoc_p <= link_if.eoc_n;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // Bounded wait: 0 host idle, 1 sequence over, 2 done count reached
  task automatic wait_for(input int kind, input int target);
    int i;
    for (i = 0; i < 4000; i++)
    begin
      if (kind == 0 && ready === 1'b1) break;
      if (kind == 1 && link_if.busy === 1'b0) break;
      if (kind == 2 && eoc_falls >= target) break;
      @(negedge ref_clk_in);
    end
    if (i == 4000)
      n_mismatch++;
  endtask : wait_for

  // One host request (0 write, 1 read, 2 start), held for one edge
  task automatic host_op(input int kind);
    wait_for(0, 0);
    case (kind)
      0: wr_req_in = 1'b1;
      1: rd_req_in = 1'b1;
      default: start_req_in = 1'b1;
    endcase
    @(negedge ref_clk_in);
    {wr_req_in, rd_req_in, start_req_in} = 3'h0;
    wait_for(0, 0);
  endtask : host_op

  // Pins or register, reads during or after; register reused at s=3
  initial
  begin
    logic [3:0] masks [6];
    logic [3:0] m;
    int         n;
    int         base;
    masks = '{4'hA, 4'h5, 4'h1, 4'h5, 4'hF, 4'h6};
    repeat (12) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    @(negedge ref_clk_in);
    check(32'(link_if.busy), 32'h0);
    for (int s = 0; s < 6; s++)
    begin
      m = (s == 5) ? (rng[3:0] | 4'h2) : masks[s];
      for (int c = 0; c < 4; c++)
      begin
        rng = xs(rng);
        codes[c] = rng[13:0];
      end
      sw_select_in = s[0];
      pick_in = s[0] ? ~m : m;
      wr_chan_in = m;
      if (s[0] && s != 3)
        host_op(0);
      repeat (2) @(negedge ref_clk_in);
      exp_q.delete();
      for (int c = 0; c < 4; c++)
        if (m[c])
          exp_q.push_back(codes[c]);
      n = exp_q.size();
      base = eoc_falls;
      host_op(2);
      check(32'(latched), 32'(m));
      if (s[0])
        check(32'(clk_src), 32'h0);
      if (!s[1])
      begin
        for (int k = 0; k < n; k++)
        begin
          wait_for(2, base + k + 1);
          host_op(1);
          check(32'(rd_data), 32'(exp_q[k]));
          if (s == 0 && k == 0)
          begin
            pick_in = 4'hF;
            host_op(2);
            host_op(1);
            check(32'(rd_data), 32'(exp_q[0]));
            check(32'(latched), 32'(m));
          end
        end
        check(32'(link_if.first_result_flag), 32'h1);
      end
      else
      begin
        wait_for(1, 0);
        check(32'(link_if.first_result_flag), 32'h1);
        for (int k = 0; k <= n; k++)
        begin
          host_op(1);
          check(32'(rd_data), 32'(exp_q[k % n]));
          check(32'(rd_first), 32'(k % n == 0));
          check(32'(link_if.first_result_flag), 32'((k + 1) % n == 0));
        end
      end
      wait_for(1, 0);
      check(32'(eoc_falls - base), 32'(n));
    end
    tally_and_finish();
  end

  // Run is near 10k cycles; cut off at 75k
  initial
  begin
    #300000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : test_adc_sequence_and_readout
